/* File: hw/hpw_top.sv */
// Host programmed write port with direct transmit queue path and strap capture
`timescale 1ns/1ps
`include "hpw_defs.svh"

// Function
// - Every host write, register or queue, is one 16-bit word taken through this write cycle.
// - A cycle starts only when select and strobe are both low, whichever falls last.
// - A cycle ends when select, strobe or both rise, in any order.
// - Data is captured at the release ending the cycle, valid from 7 ns before it; the code keeps the last clock sample with select and strobe both low.
// - With queue select high the address is not decoded and the word goes to the TX FIFO.
// - Straps are taken at reset release, held from 200 ns before to 10 ns after it.
module hpw_top #(
	parameter int STRAP_W = `HPW_STRAP_W,
	parameter int TXQ_DEPTH = `HPW_TXQ_DEPTH
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Host pins
	input wire logic DEVICE_SELECT_LOW,
	input wire logic WRITE_STROBE_LOW,
	input wire logic QUEUE_SELECT,
	input wire logic [`HPW_ADDR_W-1:0] HOST_ADDR,
	input wire logic [`HPW_DATA_W-1:0] HOST_DATA,
	// Configuration straps
	input wire logic [STRAP_W-1:0] CFG_STRAP_IN,
	output logic [STRAP_W-1:0] CFG_STRAP,
	output logic CFG_STRAP_VALID,
	// Register write port
	output logic REG_WR_VALID,
	output logic [`HPW_ADDR_W-1:0] REG_WR_ADDR,
	output logic [`HPW_DATA_W-1:0] REG_WR_DATA,
	// Transmit queue stream
	output logic TXQ_VALID,
	input wire logic TXQ_READY,
	output logic [`HPW_DATA_W-1:0] TXQ_DATA,
	// Status
	output logic WR_ACTIVE,
	output logic TXQ_OVERFLOW,
	output logic TIMING_ERR,
	output logic [15:0] TXQ_WORDS
);
	localparam logic [`HPW_CNT_W-1:0] CYCLE_MIN =
		`HPW_CNT_W'(`HPW_CYCLE_CYC - `HPW_SYNC_SLACK);
	localparam logic [`HPW_CNT_W-1:0] ASSERT_MIN = `HPW_CNT_W'(`HPW_ASSERT_CYC);
	localparam logic [`HPW_CNT_W-1:0] GAP_MIN = `HPW_CNT_W'(`HPW_GAP_CYC);

	// Pin synchronisers
	logic [1:0] cs_sync_q;
	logic [1:0] wr_sync_q;
	hpw_pkg::hpw_wr_t bus_meta_q;
	hpw_pkg::hpw_wr_t bus_q;
	logic [STRAP_W-1:0] strap_meta_q;
	logic [STRAP_W-1:0] strap_sync_q;

	// Cycle tracking
	hpw_pkg::hpw_state_t state_q;
	hpw_pkg::hpw_state_t state_d;
	logic active;
	logic cyc_start;
	logic cyc_end;
	hpw_pkg::hpw_wr_t word_q;

	// Queue staging
	logic pend_q;
	hpw_pkg::hpw_wr_t pend_word_q;
	logic fifo_in_ready;
	logic queue_end;
	logic pend_load;
	logic queue_hit;

	// Timing monitor
	logic [`HPW_CNT_W-1:0] phase_cnt_q;
	logic [`HPW_CNT_W-1:0] cycle_cnt_q;
	logic seen_cycle_q;
	logic short_assert;
	logic short_gap;
	logic short_cycle;

	// Reset release tracking
	logic [1:0] rel_q;

	// Both control pins pass two flops; nothing reads the first stage
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cs_sync_q <= 2'h3;
			wr_sync_q <= 2'h3;
		end else begin
			cs_sync_q <= {cs_sync_q[0], DEVICE_SELECT_LOW};
			wr_sync_q <= {wr_sync_q[0], WRITE_STROBE_LOW};
		end
	end

	// Address, queue select and data share the control pins' latency
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			bus_meta_q <= '0;
			bus_q <= '0;
		end else begin
			bus_meta_q <= '{to_queue: QUEUE_SELECT, addr: HOST_ADDR, data: HOST_DATA};
			bus_q <= bus_meta_q;
		end
	end

	// Joint assertion of select and strobe frames the cycle
	assign active = ~cs_sync_q[1] & ~wr_sync_q[1];

	// Gap state lets a back-to-back start skip the idle state
	always_comb begin
		state_d = state_q;
		case (state_q)
			hpw_pkg::ST_IDLE: begin
				if (active) begin
					state_d = hpw_pkg::ST_ACTIVE;
				end
			end
			hpw_pkg::ST_ACTIVE: begin
				if (!active) begin
					state_d = hpw_pkg::ST_GAP;
				end
			end
			hpw_pkg::ST_GAP: begin
				if (active) begin
					state_d = hpw_pkg::ST_ACTIVE;
				end else begin
					state_d = hpw_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = hpw_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= hpw_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign cyc_start = (state_q != hpw_pkg::ST_ACTIVE) && active;
	assign cyc_end = (state_q == hpw_pkg::ST_ACTIVE) && !active;

	// Last sample seen inside the cycle is the word; the release sample may be stale
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			word_q <= '0;
		end else if (active) begin
			word_q <= bus_q;
		end
	end

	// Register writes leave as a one-cycle strobe at the end of the cycle
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_WR_VALID <= 1'b0;
		end else begin
			REG_WR_VALID <= cyc_end && !queue_hit;
		end
	end

	// Address and data hold until the next cycle ends
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_WR_ADDR <= '0;
			REG_WR_DATA <= '0;
		end else if (cyc_end) begin
			REG_WR_ADDR <= word_q.addr;
			REG_WR_DATA <= word_q.data;
		end
	end

	// Queue select bypasses decode; the queue port address also lands here
	assign queue_hit = word_q.to_queue || (word_q.addr == `HPW_TXQ_ADDR);
	assign queue_end = cyc_end && queue_hit;
	// Staging slot frees in the same cycle the FIFO accepts it
	assign pend_load = queue_end && (!pend_q || fifo_in_ready);

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			pend_q <= 1'b0;
			pend_word_q <= '0;
		end else if (pend_load) begin
			pend_q <= 1'b1;
			pend_word_q <= word_q;
		end else if (fifo_in_ready) begin
			pend_q <= 1'b0;
		end
	end

	// Host has no wait pin, so a full queue can only be reported, not stalled
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			TXQ_OVERFLOW <= 1'b0;
		end else begin
			TXQ_OVERFLOW <= queue_end && !pend_load;
		end
	end

	// Counts accepted words only; a dropped word never reaches it
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			TXQ_WORDS <= 16'h0000;
		end else if (pend_load) begin
			TXQ_WORDS <= TXQ_WORDS + 16'h0001;
		end
	end

	// Staging word plus FIFO hold one word more than the depth
	hpw_fifo #(
		.WIDTH(`HPW_DATA_W),
		.DEPTH(TXQ_DEPTH)
	) u_txq (
		.clk(CLK_SYS),
		.rst_n(RESET_N),
		.in_valid(pend_q),
		.in_ready(fifo_in_ready),
		.in_data(pend_word_q.data),
		.out_valid(TXQ_VALID),
		.out_ready(TXQ_READY),
		.out_data(TXQ_DATA)
	);

	// Phase length: cycles spent asserted or released since the last edge
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_cnt_q <= '0;
		end else if (cyc_start || cyc_end) begin
			phase_cnt_q <= `HPW_CNT_W'(1);
		end else if (phase_cnt_q != '1) begin
			phase_cnt_q <= phase_cnt_q + `HPW_CNT_W'(1);
		end
	end

	// Start-to-start length of the host cycle
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cycle_cnt_q <= '0;
			seen_cycle_q <= 1'b0;
		end else if (cyc_start) begin
			cycle_cnt_q <= `HPW_CNT_W'(1);
			seen_cycle_q <= 1'b1;
		end else if (cycle_cnt_q != '1) begin
			cycle_cnt_q <= cycle_cnt_q + `HPW_CNT_W'(1);
		end
	end

	// Phases shorter than a clock cannot be seen, so only whole clocks are judged
	assign short_assert = cyc_end && (phase_cnt_q < ASSERT_MIN);
	assign short_gap = cyc_start && (state_q == hpw_pkg::ST_GAP)
		&& (phase_cnt_q < GAP_MIN);
	assign short_cycle = cyc_start && seen_cycle_q && (cycle_cnt_q < CYCLE_MIN);

	// Diagnostic only; one clock of slack covers synchroniser jitter
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			TIMING_ERR <= 1'b0;
		end else begin
			TIMING_ERR <= short_assert || short_gap || short_cycle;
		end
	end

	// Status trails the pins by the synchroniser depth plus the state register
	assign WR_ACTIVE = (state_q == hpw_pkg::ST_ACTIVE);

	// Reset release seen two edges late, so straps sampled near the edge are kept
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			rel_q <= 2'h0;
		end else begin
			rel_q <= {rel_q[0], 1'b1};
		end
	end

	// Strap path has no reset so it keeps tracking the pins while reset is held
	always_ff @(posedge CLK_SYS) begin
		strap_meta_q <= CFG_STRAP_IN;
		strap_sync_q <= strap_meta_q;
	end

	// Last value synchronised before the release is the one kept
	always_ff @(posedge CLK_SYS) begin
		if (!rel_q[1]) begin
			CFG_STRAP <= strap_sync_q;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			CFG_STRAP_VALID <= 1'b0;
		end else if (rel_q[1]) begin
			CFG_STRAP_VALID <= 1'b1;
		end
	end
endmodule : hpw_top

/* File: hw/hpw_defs.svh */
// Constants for the host write port: widths, timing figures and cycle counts
`ifndef HPW_DEFS_SVH
`define HPW_DEFS_SVH

`define HPW_DATA_W 16
`define HPW_ADDR_W 7
`define HPW_STRAP_W 4
`define HPW_TXQ_DEPTH 32
`define HPW_TXQ_ADDR 7'h10
`define HPW_CNT_W 8

`define HPW_CLK_NS 40
`define HPW_T_CYCLE_NS 165
`define HPW_T_ASSERT_NS 32
`define HPW_T_GAP_NS 13
`define HPW_T_DSU_NS 7
`define HPW_T_STRAP_SU_NS 200
`define HPW_T_STRAP_HD_NS 10

`define HPW_CEIL_CYC(ns) ((((ns) + `HPW_CLK_NS - 1) / `HPW_CLK_NS) < 1 ? 1 : \
	(((ns) + `HPW_CLK_NS - 1) / `HPW_CLK_NS))
`define HPW_CYCLE_CYC `HPW_CEIL_CYC(`HPW_T_CYCLE_NS)
`define HPW_ASSERT_CYC `HPW_CEIL_CYC(`HPW_T_ASSERT_NS)
`define HPW_GAP_CYC `HPW_CEIL_CYC(`HPW_T_GAP_NS)
`define HPW_SYNC_SLACK 1

`endif

/* File: hw/hpw_pkg.sv */
// Types shared by the host write port files
`include "hpw_defs.svh"
package hpw_pkg;
	typedef struct packed {
		logic to_queue;
		logic [`HPW_ADDR_W-1:0] addr;
		logic [`HPW_DATA_W-1:0] data;
	} hpw_wr_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_GAP
	} hpw_state_t;
endpackage : hpw_pkg

/* File: hw/hpw_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hpw_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = (wr_q == rd_q);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign push = in_valid & ~full;
	assign pop = out_ready & ~empty;
	assign out_data = mem[rd_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
		end else if (push) begin
			wr_q <= wr_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= '0;
		end else if (pop) begin
			rd_q <= rd_q + 1'b1;
		end
	end
endmodule : hpw_fifo

/* File: sim/hpw_asserts.sv */
// Checker for the host write port pins and queue stream
`timescale 1ns/1ps
`include "hpw_defs.svh"
module hpw_asserts (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Host pins
	input wire logic DEVICE_SELECT_LOW,
	input wire logic WRITE_STROBE_LOW,
	input wire logic QUEUE_SELECT,
	input wire logic [`HPW_ADDR_W-1:0] HOST_ADDR,
	input wire logic [`HPW_DATA_W-1:0] HOST_DATA,
	// Results
	input wire logic [3:0] CFG_STRAP,
	input wire logic CFG_STRAP_VALID,
	input wire logic REG_WR_VALID,
	input wire logic [`HPW_ADDR_W-1:0] REG_WR_ADDR,
	input wire logic [`HPW_DATA_W-1:0] REG_WR_DATA,
	input wire logic TXQ_VALID,
	input wire logic TXQ_READY,
	input wire logic [`HPW_DATA_W-1:0] TXQ_DATA,
	input wire logic WR_ACTIVE,
	input wire logic TXQ_OVERFLOW,
	input wire logic [15:0] TXQ_WORDS
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	logic both_low;
	assign both_low = !DEVICE_SELECT_LOW && !WRITE_STROBE_LOW;
	// Five samples leave room for the two-flop synchroniser
	sequence s_held; both_low[*5]; endsequence
	sequence s_ended; $fell(both_low) && WR_ACTIVE; endsequence
	property p_start; s_held |-> WR_ACTIVE; endproperty
	property p_idle; (!both_low)[*5] |-> !WR_ACTIVE; endproperty
	property p_end;
		s_ended |-> ##[1:5] (REG_WR_VALID || TXQ_OVERFLOW || $changed(TXQ_WORDS));
	endproperty
	property p_pulse; REG_WR_VALID |=> !REG_WR_VALID; endproperty
	property p_queue; s_ended ##0 QUEUE_SELECT |-> !REG_WR_VALID[*6]; endproperty
	property p_step;
		$changed(TXQ_WORDS) |-> TXQ_WORDS == $past(TXQ_WORDS) + 16'h0001;
	endproperty
	// Last pin sample before the release lies four samples behind the strobe
	property p_capture;
		REG_WR_VALID |-> REG_WR_ADDR == $past(HOST_ADDR, 4) && REG_WR_DATA == $past(HOST_DATA, 4);
	endproperty
	property p_strap; CFG_STRAP_VALID |=> CFG_STRAP_VALID && $stable(CFG_STRAP); endproperty
	property p_hold; TXQ_VALID && !TXQ_READY |=> TXQ_VALID && $stable(TXQ_DATA); endproperty
	a_start: assert property (p_start) else $error("write cycle not started");
	a_idle: assert property (p_idle) else $error("write cycle did not end");
	a_end: assert property (p_end) else $error("ended cycle had no effect");
	a_pulse: assert property (p_pulse) else $error("register pulse too long");
	a_queue: assert property (p_queue) else $error("queue write hit registers");
	a_step: assert property (p_step) else $error("queue count jumped");
	a_capture: assert property (p_capture) else $error("wrong word captured");
	a_strap: assert property (p_strap) else $error("straps moved");
	a_hold: assert property (p_hold) else $error("queue head not held");
endmodule : hpw_asserts
bind hpw_top hpw_asserts u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
	.DEVICE_SELECT_LOW(DEVICE_SELECT_LOW), .WRITE_STROBE_LOW(WRITE_STROBE_LOW),
	.QUEUE_SELECT(QUEUE_SELECT), .HOST_ADDR(HOST_ADDR), .HOST_DATA(HOST_DATA),
	.CFG_STRAP(CFG_STRAP), .CFG_STRAP_VALID(CFG_STRAP_VALID), .REG_WR_VALID(REG_WR_VALID),
	.REG_WR_ADDR(REG_WR_ADDR), .REG_WR_DATA(REG_WR_DATA), .TXQ_VALID(TXQ_VALID),
	.TXQ_READY(TXQ_READY), .TXQ_DATA(TXQ_DATA), .WR_ACTIVE(WR_ACTIVE),
	.TXQ_OVERFLOW(TXQ_OVERFLOW), .TXQ_WORDS(TXQ_WORDS));

/* File: sim/hpw_host_model.sv */
// Host bus master model driving the write pins
`timescale 1ns/1ps
`include "hpw_defs.svh"
module hpw_host_model (
	// Clock
	input wire logic clk,
	// Host pins
	output logic sel_n,
	output logic wr_n,
	output logic queue,
	output logic [`HPW_ADDR_W-1:0] addr,
	output logic [`HPW_DATA_W-1:0] data
);
	initial begin
		sel_n = 1'b1;
		wr_n = 1'b1;
		queue = 1'b0;
		addr = '0;
		data = '0;
	end
	task automatic wr(input logic qs, input logic [`HPW_ADDR_W-1:0] ad,
		input logic [`HPW_DATA_W-1:0] dt, input int n, input logic [1:0] m);
		@(posedge clk) #1;
		queue = qs;
		addr = ad;
		data = dt;
		if (m[0]) wr_n = 1'b0; else sel_n = 1'b0;
		@(posedge clk) #1;
		sel_n = 1'b0;
		wr_n = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		if (m[1]) sel_n = 1'b1; else wr_n = 1'b1;
		@(posedge clk) #1;
		sel_n = 1'b1;
		wr_n = 1'b1;
		// Hold time over: stale values would hide a late capture
		queue = ~qs;
		addr = ~ad;
		data = ~dt;
		repeat (3) @(posedge clk);
	endtask : wr
	// Two cycles 80 ns apart, shorter than the cycle minimum on purpose
	task automatic fast_pair(input logic [`HPW_ADDR_W-1:0] a0, input logic [`HPW_DATA_W-1:0] d0,
		input logic [`HPW_ADDR_W-1:0] a1, input logic [`HPW_DATA_W-1:0] d1);
		@(posedge clk) #1;
		queue = 1'b0;
		addr = a0;
		data = d0;
		sel_n = 1'b0;
		wr_n = 1'b0;
		@(posedge clk) #1;
		wr_n = 1'b1;
		@(posedge clk) #1;
		addr = a1;
		data = d1;
		wr_n = 1'b0;
		@(posedge clk) #1;
		sel_n = 1'b1;
		wr_n = 1'b1;
		repeat (3) @(posedge clk);
	endtask : fast_pair
endmodule : hpw_host_model

/* File: sim/tb_top.sv */
// Self-checking bench for the host write port
`timescale 1ns/1ps
`include "hpw_defs.svh"
module tb_top;
	logic CLK_SYS = 1'b0;
	logic RESET_N = 1'b0;
	logic TXQ_READY = 1'b0;
	logic [3:0] strap = 4'h5;
	logic sel_n, wr_n, q, cv, rv, tv, act, ovf, terr, qs;
	logic [`HPW_ADDR_W-1:0] a, ra, ad;
	logic [15:0] d, rd, td, words;
	logic [3:0] cfg;
	int bad_count = 0;
	int total_checks = 0;
	int seed = 32'h9A2F;
	int cyc = 0;
	int nq = 0;
	int ovf_n = 0;
	int rdy = 0;
	int terr_n = 0;
	bit short_on = 1'b0;
	logic [15:0] exp_q[$];
	logic [22:0] exp_r[$];
	always #20 CLK_SYS = ~CLK_SYS;
	hpw_host_model u_host (.clk(CLK_SYS), .sel_n(sel_n), .wr_n(wr_n), .queue(q), .addr(a),
		.data(d));
	hpw_top DUT (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .DEVICE_SELECT_LOW(sel_n),
		.WRITE_STROBE_LOW(wr_n), .QUEUE_SELECT(q), .HOST_ADDR(a), .HOST_DATA(d),
		.CFG_STRAP_IN(strap), .CFG_STRAP(cfg), .CFG_STRAP_VALID(cv), .REG_WR_VALID(rv),
		.REG_WR_ADDR(ra), .REG_WR_DATA(rd), .TXQ_VALID(tv), .TXQ_READY(TXQ_READY),
		.TXQ_DATA(td), .WR_ACTIVE(act), .TXQ_OVERFLOW(ovf), .TIMING_ERR(terr),
		.TXQ_WORDS(words));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	function logic to_fifo(input logic s, input logic [`HPW_ADDR_W-1:0] x);
		return s || x == `HPW_TXQ_ADDR;
	endfunction : to_fifo
	task wr(input logic s, input logic [`HPW_ADDR_W-1:0] x, input logic [15:0] y,
		input logic [1:0] m, input bit keep);
		if (!to_fifo(s, x)) exp_r.push_back({x, y});
		else if (keep) begin
			exp_q.push_back(y);
			nq++;
		end
		u_host.wr(s, x, y, 6 + {$random(seed)} % 4, m);
	endtask : wr
	always @(posedge CLK_SYS) #1 TXQ_READY <= rdy == 2 || (rdy == 1 && $random(seed) % 2);
	always @(posedge CLK_SYS) begin
		cyc++;
		if (ovf) ovf_n++;
		if (terr) terr_n++;
		if (terr) chk("timing_err", 1, short_on);
		if (rv) chk("reg_write", {ra, rd}, exp_r.size() ? exp_r.pop_front() : 23'h7FFFFF);
		if (tv && TXQ_READY) chk("txq_data", td, exp_q.size() ? exp_q.pop_front() : ~td);
		if (cyc == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge CLK_SYS);
		#1 RESET_N = 1'b1;
		repeat (3) @(posedge CLK_SYS);
		#1 strap = 4'hA;
		repeat (3) @(posedge CLK_SYS);
		chk("strap", cfg, 4'h5);
		chk("strap_valid", cv, 1'b1);
		$display("test straps done");
		rdy = 1;
		// Every framing order, both paths, queue address without select
		for (int i = 0; i < 40; i++) begin
			qs = (i < 4) ? i[0] : 1'($random(seed));
			ad = (i == 2) ? `HPW_TXQ_ADDR : 7'($random(seed));
			wr(qs, ad, 16'($random(seed)), i[1:0], 1'b1);
		end
		rdy = 2;
		repeat (20) @(posedge CLK_SYS);
		chk("reg_left", exp_r.size(), 0);
		chk("txq_left", exp_q.size(), 0);
		$display("test random done");
		rdy = 0;
		// FIFO plus staging word hold 33; the 34th is dropped
		for (int k = 0; k < 34; k++) wr(1'b1, 7'($random(seed)), 16'($random(seed)), 2'h3, k < 33);
		repeat (8) @(posedge CLK_SYS);
		chk("overflow", ovf_n, 1);
		chk("words", words, nq);
		rdy = 2;
		repeat (60) @(posedge CLK_SYS);
		chk("drain", exp_q.size(), 0);
		chk("txq_valid", tv, 1'b0);
		$display("test fill done");
		// Too-short cycles still land as register writes, and the second is flagged
		chk("timing_none", terr_n, 0);
		short_on = 1'b1;
		exp_r.push_back({7'h03, 16'hA5C3});
		exp_r.push_back({7'h04, 16'h5A3C});
		u_host.fast_pair(7'h03, 16'hA5C3, 7'h04, 16'h5A3C);
		repeat (4) @(posedge CLK_SYS);
		short_on = 1'b0;
		chk("timing_short", terr_n, 1);
		chk("reg_short", exp_r.size(), 0);
		$display("test short done");
		give_verdict();
	end
endmodule : tb_top
